// >>> hw/adcrd_core.sv
// adc readout, comparators, read-clear interrupt flags and serial register port
// How it works
// (RULE1) threshold writes apply from the next frame
// (RULE2) flag register read clears all, releases pin
// (RULE3) clearing ignores whether host accepts checksum
// (RULE4) still-present fault sets its bit again
// (RULE5) bit newly set during read survives it
// (RULE6) bit set at read start clears anyway
// (RULE7) host reads flags on pin or polls
// (RULE8) end of frame sets bit 12, pin
// (RULE9) end-of-frame pin pulse lasts 10 us
// (RULE10) four channels converted every 50 us
// (RULE11) raw bit 15 zero when fresh, read sets
// (RULE12) burst read returns four results plus flags
// (RULE13) unread results overwritten by next frame
// (RULE14) refresh during chip select held until release
// (RULE15) host transfers often, shorter than frame; the bench host model's 96-bit burst lasts 76.8 us, longer than a frame
// (RULE16) host reads within 50 us after pulse
// (RULE17) upper threshold bit 15 mode, 14 source
// (RULE18) comparator results readable in status register
// (RULE19) crossings set rising or falling flag, pin
// (RULE20) bad bit count: framing flag, no decode
// (RULE21) pin asserted while any enabled flag set; bit 12 only drives the 10 us end-of-frame pulse
`timescale 1ns/1ps
`default_nettype none
module adcrd_core
	import adcrd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	output logic misoOut,
	output logic misoOeN,
	output logic intN,
	input wire logic [3:0][11:0] rawIn,
	input wire logic [3:0][11:0] avgIn,
	input wire logic crcFaultLvl,
	input wire logic streamFaultLvl
);
	typedef struct packed {
		logic [3:0][11:0] rawRes;
		logic [3:0][11:0] avgRes;
		logic [3:0][11:0] rawPend;
		logic [3:0][11:0] avgPend;
		logic [3:0] pendV;
		logic [3:0] stale;
		logic [3:0] rdStale;
		logic [3:0] cmpRes;
		logic [3:0][15:0] upperCfg;
		logic [3:0][15:0] upperAct;
		logic [3:0][11:0] lowerThr;
		logic [3:0][11:0] lowerAct;
		logic [15:0] flags;
		logic [15:0] mask;
		logic [15:0] snap;
		logic [6:0] eocCnt;
		logic [6:0] bitCnt;
		logic [7:0] cmd;
		logic [23:0] inShift;
		logic [79:0] outShift;
		logic misoBit;
		logic readFlags;
		logic intAct;
	} adcrd_core_t;

	adcrd_core_t state_r;
	adcrd_core_t state_nxt;
	adcrd_link_if link();
	logic chanDone;
	logic [1:0] chanIdx;
	logic frameEnd;
	logic lenValid;
	logic kindOk;
	logic rdDone;

	adcrd_spi_rx u_rx
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.csN(csN),
		.sclk(sclk),
		.mosi(mosi),
		.link(link)
	);

	adcrd_frame_timer u_tmr
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.chanDone(chanDone),
		.chanIdx(chanIdx),
		.frameEnd(frameEnd)
	);

	function automatic logic inRange(input logic [5:0] a, input logic [5:0] base);
		return (a >= base) && (a < base + 6'h04);
	endfunction

	function automatic logic [1:0] chanOf(input logic [5:0] a, input logic [5:0] base);
		logic [5:0] d;
		d = a - base;
		return d[1:0];
	endfunction

	function automatic logic burstLen(input logic [6:0] len);
		return (len == LEN_BURST) || (len == LEN_BURST_CRC);
	endfunction

	function automatic logic shortLen(input logic [6:0] len);
		return (len == LEN_SHORT) || (len == LEN_CRC);
	endfunction

	function automatic logic [15:0] regRead(input adcrd_core_t s, input logic [5:0] a);
		logic [1:0] i;
		i = 2'h0;
		if (inRange(a, ADDR_RAW1))
		begin
			i = chanOf(a, ADDR_RAW1);
			return {s.stale[i], 3'h0, s.rawRes[i]}; // [RULE11]
		end
		if (inRange(a, ADDR_AVG1))
		begin
			i = chanOf(a, ADDR_AVG1);
			return {4'h0, s.avgRes[i]};
		end
		if (inRange(a, ADDR_UPPER1))
		begin
			i = chanOf(a, ADDR_UPPER1);
			return s.upperCfg[i];
		end
		if (inRange(a, ADDR_LOWER1))
		begin
			i = chanOf(a, ADDR_LOWER1);
			return {4'h0, s.lowerThr[i]};
		end
		case (a)
			ADDR_CMP: return {12'h000, s.cmpRes}; // [RULE18]
			ADDR_FLAGS: return s.flags;
			ADDR_MASK: return s.mask;
			default: return 16'h0000;
		endcase
	endfunction

	assign lenValid = burstLen(state_r.bitCnt) || shortLen(state_r.bitCnt);
	assign kindOk = state_r.cmd[CMD_BURST] ? burstLen(state_r.bitCnt) : shortLen(state_r.bitCnt);
	assign rdDone = link.csRise && kindOk && state_r.readFlags;

	always_comb
	begin
		logic [15:0] evt;
		logic [15:0] wrData;
		logic [7:0] cmdNow;
		logic [5:0] addr;
		logic [11:0] sample;
		logic cmpNew;
		evt = 16'h0000;
		wrData = 16'h0000;
		cmdNow = 8'h00;
		addr = state_r.cmd[7:2];
		sample = 12'h000;
		cmpNew = 1'b0;
		state_nxt = state_r;

		// shift in, decode command after its eighth bit
		if (link.sclkRise)
		begin
			state_nxt.inShift = {state_r.inShift[22:0], link.mosiBit};
			if (state_r.bitCnt != LEN_MAX)
				state_nxt.bitCnt = state_r.bitCnt + 7'h01;
			if (state_r.bitCnt == CMD_BITS - 7'h01)
			begin
				cmdNow = {state_r.inShift[6:0], link.mosiBit};
				state_nxt.cmd = cmdNow;
				addr = cmdNow[7:2];
				if (!cmdNow[CMD_WR] && cmdNow[CMD_BURST]
					&& (addr == ADDR_RAW1 || addr == ADDR_AVG1))
				begin
					for (int i = 0; i < 4; i++)
						state_nxt.outShift[79 - 16 * i -: 16] = regRead(state_r, addr + 6'(i)); // [RULE12]
					state_nxt.outShift[15:0] = state_r.flags;
					state_nxt.snap = state_r.flags; // [RULE6]
					state_nxt.readFlags = 1'b1;
					state_nxt.rdStale = (addr == ADDR_RAW1) ? 4'hf : 4'h0;
				end
				else if (!cmdNow[CMD_WR])
				begin
					state_nxt.outShift = {regRead(state_r, addr), 64'h0};
					if (addr == ADDR_FLAGS)
					begin
						state_nxt.snap = state_r.flags; // [RULE6]
						state_nxt.readFlags = 1'b1;
					end
					if (inRange(addr, ADDR_RAW1))
						state_nxt.rdStale[chanOf(addr, ADDR_RAW1)] = 1'b1;
				end
			end
		end
		if (link.sclkFall && state_r.bitCnt >= CMD_BITS)
		begin
			state_nxt.misoBit = state_r.outShift[79];
			state_nxt.outShift = {state_r.outShift[78:0], 1'b0};
		end
		if (!link.csLow)
		begin
			state_nxt.bitCnt = 7'h00;
			state_nxt.misoBit = 1'b0;
			state_nxt.readFlags = 1'b0;
			state_nxt.rdStale = 4'h0;
			state_nxt.cmd = 8'h00;
		end

		// end of transaction: check length, then commit
		if (link.csRise)
		begin
			if (!lenValid)
				evt[BIT_FRAMING] = 1'b1; // [RULE20]
			else if (kindOk && state_r.cmd[CMD_WR] && !state_r.cmd[CMD_BURST])
			begin
				wrData = (state_r.bitCnt == LEN_CRC) ? state_r.inShift[23:8] : state_r.inShift[15:0];
				if (inRange(addr, ADDR_UPPER1))
					state_nxt.upperCfg[chanOf(addr, ADDR_UPPER1)] = wrData; // [RULE17]
				if (inRange(addr, ADDR_LOWER1))
					state_nxt.lowerThr[chanOf(addr, ADDR_LOWER1)] = wrData[11:0];
				if (addr == ADDR_MASK)
					state_nxt.mask = wrData;
			end
			else if (kindOk)
				state_nxt.stale = state_r.stale | state_r.rdStale; // [RULE11]
		end

		// held-back refresh lands once chip select is released
		if (!link.csLow)
		begin
			for (int i = 0; i < 4; i++)
				if (state_r.pendV[i])
				begin
					state_nxt.rawRes[i] = state_r.rawPend[i]; // [RULE14]
					state_nxt.avgRes[i] = state_r.avgPend[i];
					state_nxt.stale[i] = 1'b0;
				end
			state_nxt.pendV = 4'h0;
		end

		// channel slot done: refresh and compare
		if (chanDone)
		begin
			if (link.csLow)
			begin
				state_nxt.rawPend[chanIdx] = rawIn[chanIdx]; // [RULE14]
				state_nxt.avgPend[chanIdx] = avgIn[chanIdx];
				state_nxt.pendV[chanIdx] = 1'b1;
			end
			else
			begin
				state_nxt.rawRes[chanIdx] = rawIn[chanIdx]; // [RULE13]
				state_nxt.avgRes[chanIdx] = avgIn[chanIdx];
				state_nxt.stale[chanIdx] = 1'b0; // [RULE11]
				state_nxt.pendV[chanIdx] = 1'b0;
			end
			sample = state_r.upperAct[chanIdx][BIT_SRC] ? rawIn[chanIdx] : avgIn[chanIdx]; // [RULE17]
			cmpNew = state_r.cmpRes[chanIdx];
			if (sample > state_r.upperAct[chanIdx][11:0])
				cmpNew = 1'b1;
			else if (sample < state_r.lowerAct[chanIdx])
				cmpNew = 1'b0;
			state_nxt.cmpRes[chanIdx] = cmpNew; // [RULE18]
			if (state_r.upperAct[chanIdx][BIT_MODE])
			begin
				evt[chanIdx] = sample > state_r.upperAct[chanIdx][11:0]; // [RULE19]
				evt[BIT_FALL0 + 32'(chanIdx)] = sample < state_r.lowerAct[chanIdx];
			end
			else
			begin
				evt[chanIdx] = cmpNew & ~state_r.cmpRes[chanIdx]; // [RULE19]
				evt[BIT_FALL0 + 32'(chanIdx)] = ~cmpNew & state_r.cmpRes[chanIdx];
			end
		end

		// frame boundary: load thresholds, end-of-conversion pulse
		if (state_r.eocCnt != 7'h00)
			state_nxt.eocCnt = state_r.eocCnt - 7'h01; // [RULE9]
		if (frameEnd)
		begin
			state_nxt.upperAct = state_r.upperCfg; // [RULE1]
			state_nxt.lowerAct = state_r.lowerThr;
			if (state_r.mask[BIT_EOC])
			begin
				evt[BIT_EOC] = 1'b1; // [RULE8] [RULE10]
				state_nxt.eocCnt = EOC_CYC; // [RULE9]
			end
		end

		// read-clear, then set wins, then standing faults set again
		if (rdDone)
			state_nxt.flags = state_r.flags & ~state_r.snap; // [RULE2] [RULE3] [RULE5] [RULE6] [RULE12]
		state_nxt.flags = state_nxt.flags | (evt & (state_r.mask | ~16'h00ff));
		state_nxt.flags[BIT_CRC_FAULT] = state_nxt.flags[BIT_CRC_FAULT] | crcFaultLvl; // [RULE4]
		state_nxt.flags[BIT_STREAM] = state_nxt.flags[BIT_STREAM] | streamFaultLvl; // [RULE4]
		state_nxt.intAct = (|(state_nxt.flags & state_nxt.mask & ~EOC_MASK))
			|| (state_nxt.eocCnt != 7'h00); // [RULE21] [RULE9]
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_r <= '{flags: FLAGS_RST, mask: MASK_RST, upperCfg: {4{UPPER_RST}},
				upperAct: {4{UPPER_RST}}, lowerThr: {4{LOWER_RST}}, lowerAct: {4{LOWER_RST}},
				stale: STALE_RST, default: '0};
		else
			state_r <= state_nxt;
	end

	assign misoOut = state_r.misoBit;
	assign misoOeN = ~link.csLow;
	assign intN = ~state_r.intAct;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence eocStart;
		frameEnd && state_r.mask[BIT_EOC];
	endsequence

	sequence eocLast;
		(state_r.eocCnt == 7'h01) && !frameEnd;
	endsequence

	a_thr_next_frame: assert property (frameEnd |=> state_r.upperAct == $past(state_r.upperCfg)) // [RULE1]
		else $error("thresholds not loaded at frame end");
	a_thr_hold: assert property (!frameEnd |=> $stable(state_r.upperAct)) // [RULE1]
		else $error("active threshold changed mid frame");
	a_read_clears: assert property (rdDone && !crcFaultLvl && !streamFaultLvl && !chanDone && !frameEnd
		|=> (state_r.flags & $past(state_r.snap)) == 16'h0000) // [RULE2]
		else $error("flag read did not clear snapped bits");
	a_fault_sets: assert property (crcFaultLvl |=> state_r.flags[BIT_CRC_FAULT]) // [RULE4]
		else $error("standing fault not set again");
	a_new_kept: assert property (rdDone |=> ((state_r.flags & $past(state_r.flags) & ~$past(state_r.snap))
		== ($past(state_r.flags) & ~$past(state_r.snap)))) // [RULE5]
		else $error("bit set during read was lost");
	a_eoc_flag: assert property (eocStart |=> state_r.flags[BIT_EOC] && !intN ##1 !intN) // [RULE8]
		else $error("end of conversion did not raise flag and pin");
	a_eoc_len: assert property (eocStart |=> state_r.eocCnt == EOC_CYC) // [RULE9]
		else $error("end of conversion pulse length wrong");
	a_eoc_end: assert property (eocLast |=> state_r.eocCnt == 7'h00) // [RULE9]
		else $error("end of conversion pulse did not end");
	a_refresh_held: assert property (chanDone && link.csLow |=> $stable(state_r.rawRes)) // [RULE14]
		else $error("result changed during transaction");
	a_frame_err: assert property (link.csRise && !lenValid
		|=> state_r.flags[BIT_FRAMING] && $stable(state_r.mask) && $stable(state_r.upperCfg)) // [RULE20]
		else $error("bad length not flagged or registers changed");
	a_int_level: assert property ((state_r.flags & state_r.mask & ~EOC_MASK) != 16'h0000 |-> !intN) // [RULE21]
		else $error("pin released while enabled flag set");
endmodule
`default_nettype wire

// >>> hw/adcrd_pkg.sv
// constants shared by the adc readout and interrupt block
package adcrd_pkg;
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned FRAME_NS = 50000;
	localparam int unsigned EOC_PULSE_NS = 10000;
	localparam int unsigned FRAME_CYC = FRAME_NS / CLK_NS;
	localparam int unsigned SLOT_CYC = FRAME_CYC / 4;
	localparam logic [6:0] SLOT_LAST = 7'(SLOT_CYC - 1);
	localparam logic [6:0] EOC_CYC = 7'(EOC_PULSE_NS / CLK_NS);

	localparam logic [5:0] ADDR_RAW1 = 6'h01;
	localparam logic [5:0] ADDR_AVG1 = 6'h05;
	localparam logic [5:0] ADDR_UPPER1 = 6'h09;
	localparam logic [5:0] ADDR_LOWER1 = 6'h0d;
	localparam logic [5:0] ADDR_CMP = 6'h11;
	localparam logic [5:0] ADDR_FLAGS = 6'h12;
	localparam logic [5:0] ADDR_MASK = 6'h13;

	localparam logic [6:0] CMD_BITS = 7'h08;
	localparam logic [6:0] LEN_SHORT = 7'h18;
	localparam logic [6:0] LEN_CRC = 7'h20;
	localparam logic [6:0] LEN_BURST = 7'h58;
	localparam logic [6:0] LEN_BURST_CRC = 7'h60;
	localparam logic [6:0] LEN_MAX = 7'h7f;
	localparam int unsigned CMD_WR = 1;
	localparam int unsigned CMD_BURST = 0;

	localparam int unsigned BIT_FALL0 = 4;
	localparam int unsigned BIT_CRC_FAULT = 8;
	localparam int unsigned BIT_FRAMING = 9;
	localparam int unsigned BIT_STREAM = 10;
	localparam int unsigned BIT_EOC = 12;
	localparam int unsigned BIT_STALE = 15;
	localparam int unsigned BIT_MODE = 15;
	localparam int unsigned BIT_SRC = 14;
	localparam logic [15:0] EOC_MASK = 16'h1000;

	localparam logic [15:0] FLAGS_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam logic [15:0] UPPER_RST = 16'h0000;
	localparam logic [11:0] LOWER_RST = 12'h000;
	localparam logic [3:0] STALE_RST = 4'hf;
endpackage

// >>> hw/adcrd_link_if.sv
// decoded serial-port events passed from the pin sampler to the core
`timescale 1ns/1ps
`default_nettype none
interface adcrd_link_if;
	logic csLow;
	logic csRise;
	logic sclkRise;
	logic sclkFall;
	logic mosiBit;
	modport rx
	(
		output csLow,
		output csRise,
		output sclkRise,
		output sclkFall,
		output mosiBit
	);
	modport core
	(
		input csLow,
		input csRise,
		input sclkRise,
		input sclkFall,
		input mosiBit
	);
endinterface
`default_nettype wire

// >>> hw/adcrd_spi_rx.sv
// pin sampler: three-stage synchronisers and edge finding for the serial port
`timescale 1ns/1ps
`default_nettype none
module adcrd_spi_rx
	import adcrd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic csN,
	input wire logic sclk,
	input wire logic mosi,
	adcrd_link_if.rx link
);
	typedef struct packed {
		logic [2:0] csS;
		logic [2:0] sclkS;
		logic [2:0] mosiS;
		logic csF;
		logic sclkF;
		logic mosiF;
		logic csRise;
		logic sclkRise;
		logic sclkFall;
	} adcrd_rx_t;

	adcrd_rx_t rx_r;
	adcrd_rx_t rx_nxt;

	always_comb
	begin
		rx_nxt = rx_r;
		rx_nxt.csS = {rx_r.csS[1:0], csN};
		rx_nxt.sclkS = {rx_r.sclkS[1:0], sclk};
		rx_nxt.mosiS = {rx_r.mosiS[1:0], mosi};
		// a change counts once stages two and three agree
		if (rx_r.csS[1] == rx_r.csS[2])
			rx_nxt.csF = rx_r.csS[2];
		if (rx_r.sclkS[1] == rx_r.sclkS[2])
			rx_nxt.sclkF = rx_r.sclkS[2];
		if (rx_r.mosiS[1] == rx_r.mosiS[2])
			rx_nxt.mosiF = rx_r.mosiS[2];
		rx_nxt.csRise = rx_nxt.csF & ~rx_r.csF;
		rx_nxt.sclkRise = rx_nxt.sclkF & ~rx_r.sclkF & ~rx_nxt.csF;
		rx_nxt.sclkFall = ~rx_nxt.sclkF & rx_r.sclkF & ~rx_nxt.csF;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rx_r <= '{csS: 3'h7, csF: 1'b1, default: '0};
		else
			rx_r <= rx_nxt;
	end

	assign link.csLow = ~rx_r.csF;
	assign link.csRise = rx_r.csRise;
	assign link.sclkRise = rx_r.sclkRise;
	assign link.sclkFall = rx_r.sclkFall;
	assign link.mosiBit = rx_r.mosiF;
endmodule
`default_nettype wire

// >>> hw/adcrd_frame_timer.sv
// conversion frame timer: four channel slots per frame
`timescale 1ns/1ps
`default_nettype none
module adcrd_frame_timer
	import adcrd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	output logic chanDone,
	output logic [1:0] chanIdx,
	output logic frameEnd
);
	typedef struct packed {
		logic [6:0] slotCnt;
		logic [1:0] chan;
		logic [1:0] idx;
		logic done;
		logic fend;
	} adcrd_tmr_t;

	adcrd_tmr_t tmr_r;
	adcrd_tmr_t tmr_nxt;

	always_comb
	begin
		tmr_nxt = tmr_r;
		tmr_nxt.done = 1'b0;
		tmr_nxt.fend = 1'b0;
		if (tmr_r.slotCnt == SLOT_LAST)
		begin
			tmr_nxt.slotCnt = 7'h00;
			tmr_nxt.done = 1'b1;
			tmr_nxt.idx = tmr_r.chan;
			tmr_nxt.chan = tmr_r.chan + 2'h1;
			tmr_nxt.fend = (tmr_r.chan == 2'h3);
		end
		else
			tmr_nxt.slotCnt = tmr_r.slotCnt + 7'h01;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			tmr_r <= '0;
		else
			tmr_r <= tmr_nxt;
	end

	assign chanDone = tmr_r.done;
	assign chanIdx = tmr_r.idx;
	assign frameEnd = tmr_r.fend;
endmodule
`default_nettype wire

// >>> bench/adcrd_host_model.sv
// host-side serial master model for the register port
`timescale 1ns/1ps
`default_nettype none
module adcrd_host_model
(
	input wire logic ref_clk,
	input wire logic start,
	input wire logic [6:0] nBits,
	input wire logic [95:0] txWord,
	input wire logic misoIn,
	output logic csN,
	output logic sclk,
	output logic mosi,
	output logic done,
	output logic [95:0] rxWord
);
	initial
	begin
		csN = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
		done = 1'b0;
		rxWord = '0;
	end
	// one transfer per request, 800 ns per bit (a 96-bit burst outlasts a frame), with cs gap
	always @(posedge ref_clk)
	begin
		if (start === 1'b1)
		begin
			rxWord = '0;
			#37;
			csN = 1'b0;
			for (int i = int'(nBits) - 1; i >= 0; i--)
			begin
				mosi = txWord[i];
				#400;
				sclk = 1'b1;
				#400;
				rxWord = {rxWord[94:0], misoIn};
				sclk = 1'b0;
			end
			#400;
			csN = 1'b1;
			mosi = ~mosi;
			repeat (12) @(posedge ref_clk);
			done <= 1'b1;
			@(posedge ref_clk);
			done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> bench/adc_readout_interrupt_logic_tb.sv
// self-checking bench for the adc readout and interrupt block
`timescale 1ns/1ps
`default_nettype none
module adc_readout_interrupt_logic_tb;
	import adcrd_pkg::*;
	logic ref_clk;
	logic rst;
	logic start;
	logic [6:0] nBits;
	logic [95:0] txWord;
	logic csN;
	logic sclk;
	logic mosi;
	logic done;
	logic [95:0] rxWord;
	logic misoOut;
	logic misoOeN;
	logic intN;
	logic [3:0][11:0] rawIn;
	logic [3:0][11:0] avgIn;
	logic crcFaultLvl;
	logic streamFaultLvl;
	logic [16:0] expQ[$];
	logic [16:0] expEntry;
	logic [11:0] oldRaw;
	logic [11:0] thr;
	int cyc;
	int nMismatch;
	int checks;
	int n;

	adcrd_core i_dut (.ref_clk(ref_clk), .rst(rst), .csN(csN), .sclk(sclk), .mosi(mosi), .misoOut(misoOut),
		.misoOeN(misoOeN), .intN(intN), .rawIn(rawIn), .avgIn(avgIn), .crcFaultLvl(crcFaultLvl),
		.streamFaultLvl(streamFaultLvl));
	adcrd_host_model i_host (.ref_clk(ref_clk), .start(start), .nBits(nBits), .txWord(txWord),
		.misoIn(misoOut), .csN(csN), .sclk(sclk), .mosi(mosi), .done(done), .rxWord(rxWord));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cyc <= 0;
		else
			cyc <= cyc + 1;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bail();
		nMismatch++;
		$display("wait limit reached at %0t", $time);
		print_verdict();
	endtask
	task automatic step();
		@(posedge ref_clk);
		#2;
	endtask
	task automatic xfer(input logic [6:0] len, input logic [95:0] tx);
		int k;
		step();
		nBits = len;
		txWord = tx;
		start = 1'b1;
		step();
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			step();
			k++;
		end
		if (k >= 3000)
			bail();
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		expQ.push_back({1'b1, e});
		xfer(7'd24, {72'h0, a, 2'b00, 16'h0000});
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		expQ.push_back(17'h0);
		xfer(7'd24, {72'h0, a, 2'b10, d});
	endtask
	task automatic wait_mod(input int target);
		int k;
		k = 0;
		while (cyc % 500 != target && k < 600)
		begin
			step();
			k++;
		end
		if (k >= 600)
			bail();
	endtask

	// results leave the host model one cycle after done; the oldest note is matched
	always @(posedge ref_clk)
	begin
		if (done === 1'b1 && expQ.size() > 0)
		begin
			expEntry = expQ.pop_front();
			if (expEntry[16])
				check(rxWord[15:0], expEntry[15:0]);
		end
	end

	initial
	begin
		void'($urandom(32'h810c6832));
		rst = 1'b1;
		start = 1'b0;
		nBits = 7'h0;
		txWord = '0;
		crcFaultLvl = 1'b0;
		streamFaultLvl = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rawIn[i] = 12'($urandom);
			avgIn[i] = (i == 0) ? 12'h000 : (12'($urandom) | 12'h001);
		end
		repeat (3) @(posedge ref_clk);
		#2;
		rst = 1'b0;

		check({14'h0, misoOeN, intN}, 16'h0003);
		rd(ADDR_MASK, MASK_RST);
		rd(ADDR_FLAGS, FLAGS_RST);
		$display("test reset done");

		wr(ADDR_MASK, EOC_MASK);
		wait_int();
		n = 0;
		while (intN === 1'b0 && n < 300)
		begin
			step();
			n++;
		end
		check(16'(n), {9'h0, EOC_CYC});
		while (intN !== 1'b0 && n < 1000)
		begin
			step();
			n++;
		end
		check(16'(n), 16'd500);
		rd(ADDR_FLAGS, EOC_MASK);
		rd(ADDR_FLAGS, 16'h0000);
		wr(ADDR_MASK, 16'h0000);
		rd(ADDR_FLAGS, EOC_MASK);
		$display("test end of conversion done");

		wait_mod(0);
		for (int i = 0; i < 4; i++)
			rawIn[i] = 12'($urandom);
		for (int i = 0; i < 4; i++)
		begin
			wait_mod((125 * (i + 1) + 5) % 500);
			rd(6'(ADDR_RAW1 + i), {4'h0, rawIn[i]});
			rd(6'(ADDR_RAW1 + i), {4'h8, rawIn[i]});
		end
		wait_mod(20);
		oldRaw = rawIn[0];
		rawIn[0] = (oldRaw ^ 12'h5a5) | 12'h001;
		wait_mod(100);
		rd(ADDR_RAW1, {4'h0, oldRaw});
		rd(ADDR_RAW1, {4'h0, rawIn[0]});
		$display("test raw results done");

		wr(ADDR_MASK, 16'h0011);
		thr = rawIn[0] - 12'h001;
		wait_mod(10);
		wr(ADDR_UPPER1, {4'h4, thr});
		rd(ADDR_CMP, 16'h000e);
		wait_mod(130);
		check({15'h0, intN}, 16'h0000);
		rd(ADDR_CMP, 16'h000f);
		rd(ADDR_UPPER1, {4'h4, thr});
		crcFaultLvl = 1'b1;
		streamFaultLvl = 1'b1;
		rd(ADDR_FLAGS, 16'h0501);
		check({15'h0, intN}, 16'h0001);
		rd(ADDR_FLAGS, 16'h0500);
		crcFaultLvl = 1'b0;
		streamFaultLvl = 1'b0;
		rd(ADDR_FLAGS, 16'h0500);
		rd(ADDR_FLAGS, 16'h0000);
		$display("test comparators and faults done");

		expQ.push_back(17'h0);
		xfer(7'd25, {71'h0, ADDR_MASK, 2'b10, 16'hffff, 1'b0});
		rd(ADDR_MASK, 16'h0011);
		rd(ADDR_FLAGS, 16'h0200);
		$display("test framing done");

		expQ.push_back(17'h0);
		xfer(7'd25, {71'h0, ADDR_MASK, 2'b10, 16'hffff, 1'b0});
		expQ.push_back(17'h0);
		xfer(7'd96, {ADDR_RAW1, 2'b01, 80'h0, 8'($urandom)});
		check({4'h0, rxWord[83:72]}, {4'h0, rawIn[0]});
		check(rxWord[23:8], 16'h0200);
		rd(ADDR_FLAGS, 16'h0000);
		$display("test burst read done");
		repeat (4) step();
		print_verdict();
	end

	task automatic wait_int();
		int k;
		k = 0;
		while (intN !== 1'b0 && k < 1000)
		begin
			step();
			k++;
		end
		if (k >= 1000)
			bail();
	endtask
endmodule
`default_nettype wire
